// *** ext_mem_map.svh ***
`ifndef EXT_MEM_MAP_SVH
`define EXT_MEM_MAP_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define EMC_OFS_BANK0_CTRL   8'h00
`define EMC_OFS_BANK1_CTRL   8'h04
`define EMC_OFS_STATUS       8'h08

// ****************************************************************
// Field positions.
// ****************************************************************
`define EMC_BC_WIDTH_LO      0
`define EMC_BC_WIDTH_HI      1
`define EMC_BC_IGNORE_BIT    2
`define EMC_ST_HELD_BIT      0
`define EMC_ST_BUSY_BIT      1
`define EMC_ST_PROGRAM_WIDTH_SELECT_BIT      2

// ****************************************************************
// Reset values of the bank width fields, chosen by the width pin.
// ****************************************************************
`define EMC_RST_WIDTH_PRGW0  2'h2
`define EMC_RST_WIDTH_PRGW1  2'h1
`define EMC_RST_BUS_CTRL     3'h0

// ****************************************************************
// Idle levels of the strobe pins.
// ****************************************************************
`define EMC_STROBE_IDLE      4'hf

`endif

// *** ext_mem_pkg.sv ***
package ext_mem_pkg;

    // Controller states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_FLOAT,
        ST_HELD
    } state_t;

    // Bank width codes held in the width field of a bus control register.
    typedef enum logic [1:0] {
        WIDTH_8  = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_32 = 2'h2,
        WIDTH_RSV = 2'h3
    } width_t;

    // One request from the core's memory access logic.
    typedef struct packed {
        logic        write;
        logic        bank;
        logic        fetch;
        logic [1:0]  sub;
        logic [23:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    // Whole state of the controller.
    typedef struct packed {
        state_t      state;
        width_t      width;
        logic        write;
        logic        bank;
        logic        fetch2;
        logic        phase;
        logic [1:0]  sub;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        resp_valid;
        logic [31:0] reg_rdata;
        logic [2:0]  bank0_ctrl;
        logic [2:0]  bank1_ctrl;
        logic [3:0]  pin_meta;
        logic [3:0]  pin_sync;
        logic [31:0] data_meta;
        logic [31:0] data_sync;
    } ctl_state_t;

endpackage

// *** ext_mem_strobe1_hold_ctrl.sv ***
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_map.svh"


module ext_mem_strobe1_hold_ctrl
    import ext_mem_pkg::*;
(
    input  wire logic        i_clk,           // 100 MHz clock.
    input  wire logic        i_rst,           // Synchronous reset.
    // Register port.
    input  wire logic [7:0]  i_reg_addr,      // Register byte address.
    input  wire logic [31:0] i_reg_wdata,     // Write data.
    input  wire logic        i_reg_wr,        // Write strobe.
    input  wire logic        i_reg_rd,        // Read strobe.
    output logic      [31:0] o_reg_rdata,     // Read data, next cycle.
    // Core request port.
    input  wire logic        i_req_valid,     // Request offered.
    input  wire mem_req_t    i_req,           // Request contents.
    output logic             o_req_ready,     // Request taken.
    output logic             o_resp_valid,    // Transfer finished.
    output logic      [31:0] o_resp_rdata,    // Read or fetch data.
    // External pins.
    output logic      [23:0] o_addr,          // Address outputs.
    output logic             o_addr_oe,       // Address and control drive.
    output logic      [31:0] o_data,          // Data outputs.
    output logic             o_data_oe,       // Data drive.
    input  wire logic [31:0] i_data,          // Data inputs.
    output logic             o_rnw,           // High read, low write.
    output logic      [3:0]  o_bank0_strobe_group, // Bank 0 strobes.
    output logic      [3:0]  o_bank1_strobe_group, // Bank 1 strobes.
    output logic             o_peripheral_io_strobe, // I/O strobe.
    input  wire logic        i_ready_n,       // External ready, low.
    input  wire logic        i_bus_req_n,     // Bus request, low.
    output logic             o_bus_grant_ack, // Grant, low.
    output logic             o_bus_grant_ack_oe, // Grant drive.
    input  wire logic        i_program_width_select, // Fetch width.
    input  wire logic        i_force_all_float_n     // Float all, low.
);

    // ****************************************************************
    // Strobe line levels for one access.
    // ****************************************************************

    // Active-low strobe levels for a bank of the given width. On a wide
    // bank all four lines are byte enables. On narrower banks the upper
    // lines carry the low address bits that a narrow word cannot decode,
    // so the same pins serve as enables or as address as the width says.
    // A line that has no use at a given width rests high.
    function automatic logic [3:0] strobe_lines(input width_t w,
                                                input logic [1:0] sub);
        logic [3:0] s;
        s = `EMC_STROBE_IDLE;
        unique case (w)
            WIDTH_32: s = 4'h0;
            WIDTH_16: s = {sub[0], 1'b1, 2'b00};
            WIDTH_8:  s = {sub[0], sub[1], 1'b1, 1'b0};
            default:  s = 4'h0;
        endcase
        return s;
    endfunction

    // ****************************************************************
    // State.
    // ****************************************************************

    // The whole controller state, synchronisers included, is one struct,
    // so a single register process holds every flip-flop of the block.
    ctl_state_t state_reg;
    ctl_state_t state_next;

    logic ready_n_s;
    logic bus_req_n_s;
    logic program_width_select_s;
    logic float_n_s;
    logic hold_want;
    logic bus_driven;
    logic [3:0] lines;
    logic strobing;

    // Second synchroniser stage gives the pin levels used by logic.
    // Ready and the data pins pass the same two stages, so a ready level
    // seen here always pairs with the data that stood beside it. The cost
    // is that a ready level lingers here for two cycles after the pin has
    // let go, which the sequencing below has to wait out.
    assign ready_n_s   = state_reg.pin_sync[0];
    assign bus_req_n_s = state_reg.pin_sync[1];
    assign program_width_select_s      = state_reg.pin_sync[2];
    assign float_n_s   = state_reg.pin_sync[3];

    // Hold is wanted on a low request unless the ignore bit is set.
    assign hold_want = ~bus_req_n_s
                     & ~state_reg.bank0_ctrl[`EMC_BC_IGNORE_BIT];

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************

    // Computes the whole next state from the current one and inputs.
    always_comb begin
        state_next = state_reg;
        state_next.resp_valid = 1'b0;
        state_next.reg_rdata = 32'h0;
        state_next.pin_meta = {i_force_all_float_n,
                               i_program_width_select,
                               i_bus_req_n, i_ready_n};
        state_next.pin_sync = state_reg.pin_meta;
        state_next.data_meta = i_data;
        state_next.data_sync = state_reg.data_meta;

        // Register writes. Unmapped offsets are ignored, and the second
        // bank has no ignore bit, so that bit always reads back as zero.
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `EMC_OFS_BANK0_CTRL:
                    state_next.bank0_ctrl = i_reg_wdata[2:0];
                `EMC_OFS_BANK1_CTRL:
                    state_next.bank1_ctrl = {1'b0, i_reg_wdata[1:0]};
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle.
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `EMC_OFS_BANK0_CTRL:
                    state_next.reg_rdata = {29'h0, state_reg.bank0_ctrl};
                `EMC_OFS_BANK1_CTRL:
                    state_next.reg_rdata = {29'h0, state_reg.bank1_ctrl};
                `EMC_OFS_STATUS: begin
                    state_next.reg_rdata[`EMC_ST_HELD_BIT] =
                        (state_reg.state == ST_HELD);
                    state_next.reg_rdata[`EMC_ST_BUSY_BIT] =
                        (state_reg.state == ST_ACCESS);
                    state_next.reg_rdata[`EMC_ST_PROGRAM_WIDTH_SELECT_BIT] = program_width_select_s;
                end
                default: state_next.reg_rdata = 32'h0;
            endcase
        end

        // Access sequencing and bus hold. An access runs until ready is
        // seen; a split fetch runs its lower half, rests with the strobes
        // released until the lower half's ready has drained, then runs
        // its upper half. A hold request never cuts an access short: it
        // is only looked at once the bus is idle or the access has ended.
        unique case (state_reg.state)
            ST_IDLE: begin
                if (hold_want) begin
                    state_next.state = ST_FLOAT;
                end else if (i_req_valid && ready_n_s) begin
                    state_next.state = ST_ACCESS;
                    state_next.write = i_req.write & ~i_req.fetch;
                    state_next.bank = i_req.bank;
                    state_next.addr = i_req.addr;
                    state_next.wdata = i_req.wdata;
                    state_next.sub = i_req.sub;
                    state_next.phase = 1'b0;
                    state_next.rdata = 32'h0;
                    state_next.fetch2 = i_req.fetch & program_width_select_s;
                    if (i_req.fetch) begin
                        state_next.width = program_width_select_s ? WIDTH_16
                                                  : WIDTH_32;
                        state_next.sub = 2'b00;
                    end else if (i_req.bank) begin
                        state_next.width = width_t'(state_reg.bank1_ctrl[1:0]);
                    end else begin
                        state_next.width = width_t'(state_reg.bank0_ctrl[1:0]);
                    end
                end
            end
            ST_ACCESS: begin
                if (state_reg.phase && !state_reg.fetch2) begin
                    // Rest between the halves of a split fetch until the
                    // lower half's ready has left the synchroniser.
                    if (ready_n_s) begin
                        state_next.fetch2 = 1'b1;
                    end
                end else if (!ready_n_s) begin
                    if (state_reg.fetch2 && !state_reg.phase) begin
                        // First half of a split fetch; rest, then fetch
                        // the upper half.
                        state_next.rdata[15:0] =
                            state_reg.data_sync[15:0];
                        state_next.phase = 1'b1;
                        state_next.fetch2 = 1'b0;
                        state_next.sub = 2'b01;
                    end else begin
                        if (state_reg.fetch2) begin
                            state_next.rdata[31:16] =
                                state_reg.data_sync[15:0];
                        end else if (!state_reg.write) begin
                            state_next.rdata = state_reg.data_sync;
                        end
                        state_next.resp_valid = 1'b1;
                        state_next.state = hold_want ? ST_FLOAT
                                                     : ST_IDLE;
                    end
                end
            end
            ST_FLOAT: begin
                // Outputs float here for one cycle before the grant shows.
                state_next.state = hold_want ? ST_HELD : ST_IDLE;
            end
            ST_HELD: begin
                if (!hold_want) begin
                    state_next.state = ST_IDLE;
                end
            end
        endcase

        // Reset; bank widths follow the synchronised width pin. Reset must
        // stand for at least three edges, so that the width pin has crossed
        // both synchroniser stages before the widths are loaded from it.
        if (i_rst) begin
            state_next.state = ST_IDLE;
            state_next.width = WIDTH_32;
            state_next.write = 1'b0;
            state_next.bank = 1'b0;
            state_next.fetch2 = 1'b0;
            state_next.phase = 1'b0;
            state_next.sub = 2'b00;
            state_next.addr = 24'h0;
            state_next.wdata = 32'h0;
            state_next.rdata = 32'h0;
            state_next.resp_valid = 1'b0;
            state_next.reg_rdata = 32'h0;
            state_next.bank0_ctrl = `EMC_RST_BUS_CTRL;
            state_next.bank1_ctrl = `EMC_RST_BUS_CTRL;
            state_next.bank0_ctrl[1:0] = program_width_select_s ? `EMC_RST_WIDTH_PRGW1
                                                : `EMC_RST_WIDTH_PRGW0;
            state_next.bank1_ctrl[1:0] = program_width_select_s ? `EMC_RST_WIDTH_PRGW1
                                                : `EMC_RST_WIDTH_PRGW0;
        end
    end

    // Registers the whole state. Reset is folded into the next-state
    // logic, so the synchronisers keep sampling their pins through it.
    always_ff @(posedge i_clk) begin
        state_reg <= state_next;
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************

    // Pins are driven except while held, floating, or forced off.
    // The float state lets the pins go one cycle before the grant shows,
    // so an outside master never meets a driven bus.
    assign bus_driven = float_n_s
                      && (state_reg.state != ST_FLOAT)
                      && (state_reg.state != ST_HELD);

    // Strobe levels of the running access.
    assign lines = strobe_lines(state_reg.width, state_reg.sub);

    // Strobes rest high in the gap between the halves of a split fetch.
    assign strobing = (state_reg.state == ST_ACCESS)
                    && !(state_reg.phase && !state_reg.fetch2);

    // Request and answer signals.
    // A request waits while the last access's ready still lingers in the
    // synchroniser, so that a stale ready never ends the next access.
    assign o_req_ready = (state_reg.state == ST_IDLE) && !hold_want
                       && ready_n_s && !i_rst;
    assign o_resp_valid = state_reg.resp_valid;
    assign o_resp_rdata = state_reg.rdata;
    assign o_reg_rdata = state_reg.reg_rdata;

    // External bus pins.
    assign o_addr = state_reg.addr;
    assign o_addr_oe = bus_driven;
    assign o_data = state_reg.wdata;
    assign o_data_oe = bus_driven && state_reg.write
                     && (state_reg.state == ST_ACCESS);
    assign o_rnw = (state_reg.state == ST_ACCESS) ? ~state_reg.write
                                                  : 1'b1;
    assign o_bank0_strobe_group =
        (strobing && !state_reg.bank)
        ? lines : `EMC_STROBE_IDLE;
    assign o_bank1_strobe_group =
        (strobing && state_reg.bank)
        ? lines : `EMC_STROBE_IDLE;
    assign o_peripheral_io_strobe = 1'b1;

    // Grant is low only once outputs have floated. The grant pin itself
    // is only let go when every bus output is forced off.
    assign o_bus_grant_ack = (state_reg.state != ST_HELD);
    assign o_bus_grant_ack_oe = float_n_s;

endmodule // ext_mem_strobe1_hold_ctrl

`default_nettype wire

// *** ext_mem_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Pin protocol checks for the external bus controller.
// ****************************************************************
module ext_mem_chk (
    input wire logic       i_clk,                // Clock.
    input wire logic       i_rst,                // Reset.
    input wire logic       i_ready_n,            // Ready pin.
    input wire logic       i_bus_req_n,          // Bus request.
    input wire logic       o_bus_grant_ack,      // Grant, low.
    input wire logic       o_addr_oe,            // Bus drive.
    input wire logic       o_data_oe,            // Data drive.
    input wire logic       o_rnw,                // Direction.
    input wire logic [3:0] o_bank0_strobe_group, // Bank 0 strobes.
    input wire logic [3:0] o_bank1_strobe_group, // Bank 1 strobes.
    input wire logic       o_req_ready,          // Request taken.
    input wire logic       o_resp_valid          // Transfer done.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Bus pin checks; each ties an output to its cause.
    a_ack_floats: assert property (
        !o_bus_grant_ack |-> !o_addr_oe && !o_data_oe)
        else $error("grant low while bus driven");
    a_ack_cause: assert property (
        $fell(o_bus_grant_ack) |-> !$past(i_bus_req_n, 3))
        else $error("grant without request");
    a_ack_return: assert property (
        i_bus_req_n [*5] |-> o_bus_grant_ack)
        else $error("grant kept after release");
    a_held_idle: assert property (
        !o_bus_grant_ack |-> !o_req_ready && !o_resp_valid)
        else $error("transfer while held");
    a_ready_first: assert property (
        i_ready_n [*4] |-> !o_resp_valid)
        else $error("transfer ended without ready");
    a_write_dir: assert property (
        o_data_oe |-> !o_rnw)
        else $error("data driven while direction reads");
    a_read_dir: assert property (
        o_addr_oe && o_bank1_strobe_group != 4'hf && !o_data_oe |-> o_rnw)
        else $error("read access with direction low");
    a_line0_enable: assert property (
        o_addr_oe && o_bank1_strobe_group != 4'hf
        |-> !o_bank1_strobe_group[0])
        else $error("lowest byte enable not active");
    a_float_idle: assert property (
        $fell(o_addr_oe) |-> o_resp_valid
        || ($past(o_bank1_strobe_group) == 4'hf
        && $past(o_bank0_strobe_group) == 4'hf))
        else $error("bus floated in mid access");
endmodule // ext_mem_chk

bind ext_mem_strobe1_hold_ctrl ext_mem_chk ext_mem_chk_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ready_n(i_ready_n),
    .i_bus_req_n(i_bus_req_n), .o_bus_grant_ack(o_bus_grant_ack),
    .o_addr_oe(o_addr_oe), .o_data_oe(o_data_oe), .o_rnw(o_rnw),
    .o_bank0_strobe_group(o_bank0_strobe_group),
    .o_bank1_strobe_group(o_bank1_strobe_group),
    .o_req_ready(o_req_ready), .o_resp_valid(o_resp_valid));
`default_nettype wire

// *** ext_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Memory bank on the far side, with a settable wait.
// ****************************************************************
module ext_mem_model (
    input wire logic        i_clk,    // Clock.
    input wire logic [23:0] i_addr,   // Address pins.
    input wire logic        i_oe,     // Bus driven.
    input wire logic        i_rnw,    // Direction.
    input wire logic [3:0]  i_st,     // Both strobe groups, ANDed.
    input wire logic [31:0] i_wdata,  // Data from controller.
    input wire logic [3:0]  i_wait,   // Cycles before ready.
    output logic     [31:0] o_rdata,  // Data to controller.
    output logic            o_ready_n // Ready, low.
);
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0;
    logic [3:0]  cnt = 4'h0;
    logic        act;
    logic [31:0] word;

    assign act = i_oe && i_st != 4'hf;
    assign word = mem[i_addr[3:0]];
    // Ready only once the wait has run out in this access.
    assign o_ready_n = !(act && cnt >= i_wait);
    // Top line high selects the upper half on the low lanes.
    assign o_rdata = (act && i_rnw) ? (i_st[3] ? {2{word[31:16]}} : word)
                                    : ~last;

    // Count access cycles, store writes, keep the released lanes moving.
    always @(posedge i_clk) begin
        cnt <= act ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
        last <= o_rdata;
        if (act && !i_rnw) begin
            mem[i_addr[3:0]] <= i_wdata;
        end
    end
endmodule // ext_mem_model
`default_nettype wire

// *** test_ext_mem_strobe1_hold_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Directed tests of the strobe and bus grant controller.
// ****************************************************************
module test_ext_mem_strobe1_hold_ctrl;
    import ext_mem_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  raddr = 8'h00;
    logic [31:0] rwdata = 32'h0;
    logic        rwr = 1'b0, rrd = 1'b0, qv = 1'b0, breq_n = 1'b1;
    logic        pw = 1'b0, qrdy, rv, aoe, doe, rnw, ack, rdy_n, iost, ackoe;
    mem_req_t    q = '0;
    logic [3:0]  wcyc = 4'h1, st0, st1, pst = 4'hf, sst = 4'hf;
    logic [31:0] rrdata, resp, dout, din, got;
    logic [23:0] addr;
    logic        srnw = 1'b1;
    int          starts = 0, n0, compares = 0, miscompares = 0;
    logic [1:0]  wtab [5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h3};
    logic [1:0]  stab [5] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h3};
    logic [3:0]  etab [5] = '{4'hc, 4'h4, 4'h6, 4'ha, 4'h0};

    always #5 i_clk = ~i_clk;

    ext_mem_strobe1_hold_ctrl ext_mem_strobe1_hold_ctrl_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(raddr),
        .i_reg_wdata(rwdata), .i_reg_wr(rwr), .i_reg_rd(rrd),
        .o_reg_rdata(rrdata), .i_req_valid(qv), .i_req(q),
        .o_req_ready(qrdy), .o_resp_valid(rv), .o_resp_rdata(resp),
        .o_addr(addr), .o_addr_oe(aoe), .o_data(dout), .o_data_oe(doe),
        .i_data(din), .o_rnw(rnw), .o_bank0_strobe_group(st0),
        .o_bank1_strobe_group(st1), .o_peripheral_io_strobe(iost),
        .i_ready_n(rdy_n), .i_bus_req_n(breq_n), .o_bus_grant_ack(ack),
        .o_bus_grant_ack_oe(ackoe), .i_program_width_select(pw),
        .i_force_all_float_n(1'b1));

    ext_mem_model ext_mem_model_i (
        .i_clk(i_clk), .i_addr(addr), .i_oe(aoe), .i_rnw(rnw),
        .i_st(st0 & st1), .i_wdata(dout), .i_wait(wcyc),
        .o_rdata(din), .o_ready_n(rdy_n));

    // Record bank 1 strobe patterns and count distinct access phases.
    always @(posedge i_clk) begin
        pst <= st1;
        if (st1 != 4'hf) begin
            sst <= st1;
            srnw <= rnw;
        end
        if (st1 != 4'hf && st1 != pst) begin
            starts <= starts + 1;
        end
    end

    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        raddr <= a;
        rwdata <= d;
        rwr <= 1'b1;
        @(posedge i_clk);
        rwr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string what);
        raddr <= a;
        rrd <= 1'b1;
        @(posedge i_clk);
        rrd <= 1'b0;
        @(posedge i_clk);
        chk(what, e, rrdata);
    endtask

    // One bank 1 transfer; the answer is taken where it stands.
    task automatic xfer(input logic w, f, input logic [1:0] s,
                        input logic [31:0] d);
        int n;
        q <= '{write: w, bank: 1'b1, fetch: f, sub: s, addr: 24'h3,
               wdata: d};
        qv <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (qrdy !== 1'b1 && n < 50);
        qv <= 1'b0;
        while (rv !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        got = resp;
        if (n >= 100) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (ack !== lvl && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic do_reset(input logic w);
        pw <= w;
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
    endtask

    // Main sequence.
    initial begin
        @(posedge i_clk);
        do_reset(1'b0);
        rchk(8'h00, 32'h2, "bank0 ctrl");
        rchk(8'h04, 32'h2, "bank1 ctrl");
        rchk(8'h08, 32'h0, "status");
        wr(8'h0c, 32'hffff_ffff);
        rchk(8'h0c, 32'h0, "unmapped");
        rchk(8'h00, 32'h2, "bank0 kept");
        $display("test reset values done");
        wcyc <= 4'h5;
        xfer(1'b1, 1'b0, 2'h0, 32'ha5c3_0f96);
        chk("write strobes", 32'h0, {28'h0, sst});
        chk("write rnw", 32'h0, {31'h0, srnw});
        chk("io strobe idle", 32'h1, {31'h0, iost});
        xfer(1'b0, 1'b0, 2'h0, 32'h0);
        chk("read data", 32'ha5c3_0f96, got);
        chk("read rnw", 32'h1, {31'h0, srnw});
        n0 = starts;
        xfer(1'b0, 1'b1, 2'h0, 32'h0);
        chk("fetch word", 32'ha5c3_0f96, got);
        chk("fetch phases", 32'h1, starts - n0);
        $display("test wide bank done");
        for (int k = 0; k < 5; k++) begin
            wr(8'h04, {30'h0, wtab[k]});
            xfer(1'b0, 1'b0, stab[k], 32'h0);
            chk("narrow strobes", {28'h0, etab[k]}, {28'h0, sst});
        end
        wr(8'h04, 32'h2);
        $display("test narrow banks done");
        fork
            xfer(1'b0, 1'b0, 2'h0, 32'h0);
            begin
                repeat (3) @(posedge i_clk);
                breq_n <= 1'b0;
            end
        join
        chk("read under request", 32'ha5c3_0f96, got);
        wait_ack(1'b0);
        chk("bus drive held", 32'h0, {31'h0, aoe});
        chk("grant drive held", 32'h1, {31'h0, ackoe});
        rchk(8'h08, 32'h1, "status held");
        breq_n <= 1'b1;
        wait_ack(1'b1);
        wr(8'h00, 32'h6);
        breq_n <= 1'b0;
        xfer(1'b0, 1'b0, 2'h0, 32'h0);
        chk("read ignoring request", 32'ha5c3_0f96, got);
        chk("grant ignored", 32'h1, {31'h0, ack});
        breq_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        wr(8'h00, 32'h2);
        $display("test bus grant done");
        do_reset(1'b1);
        rchk(8'h00, 32'h1, "bank0 ctrl narrow");
        rchk(8'h04, 32'h1, "bank1 ctrl narrow");
        rchk(8'h08, 32'h4, "status pin");
        n0 = starts;
        xfer(1'b0, 1'b1, 2'h0, 32'h0);
        chk("split fetch word", 32'ha5c3_0f96, got);
        chk("split fetch phases", 32'h2, starts - n0);
        $display("test split fetch done");
        summarize();
    end
endmodule // test_ext_mem_strobe1_hold_ctrl
`default_nettype wire
